// ===== hdl/spi_cmd_consts.vh
// ----------------------------------------------------------------------------
// Contract
// - Read: opcode, address byte, then data out.
// - Pointer advances after every byte shifted out.
// - Raising chip select ends a sequential read.
// - Fast receive read presets pointer from n,m.
// - Chip select rise clears read buffer's full flag.
// - Further write bytes go to successive addresses.
// - Byte commits on the rising edge of bit zero.
// - Partial byte at chip select rise is dropped.
// - Fast transmit load presets pointer from a,b,c.
// - Request command sets transmit request per selected buffer.
// - Request command with zero selection does nothing.
// - Quick status byte repeats while clocks continue.
// - Receive status byte repeats while clocks continue.
// - Receive status bits 7,6 mirror full flags.
// - Bit 4 extended, bit 3 remote indication.
// - Bits 2..0 give matching filter code.
// - Both buffers full: bits 4..0 from buffer zero.
// - Masked write changes only bits with mask one.
// - Non-modifiable register: mask forced to all ones.
// - Reset opcode restores defaults and configuration mode.
// - First byte after chip select fall is instruction.
// - Sample input on rise, drive output on fall.
// ----------------------------------------------------------------------------
`ifndef SPI_CMD_CONSTS_VH
`define SPI_CMD_CONSTS_VH

// ----------------------------------------------------------------------------
// Instruction codes and match masks
// ----------------------------------------------------------------------------
`define OP_RESET 8'hC0
`define OP_READ 8'h03
`define OP_WRITE 8'h02
`define OP_BITMOD 8'h05
`define OP_RDSTAT 8'hA0
`define OP_RXSTAT 8'hB0
`define OPM_RDRX 8'hF9
`define OPV_RDRX 8'h90
`define OPM_LDTX 8'hF8
`define OPV_LDTX 8'h40
`define OPM_RTS 8'hF8
`define OPV_RTS 8'h80

// ----------------------------------------------------------------------------
// Register map pieces, field positions and reset values
// ----------------------------------------------------------------------------
`define ADDR_INTFLAG 7'h2C
`define TXB_ROW0 3'h3
`define RXB_ROW0 3'h6
`define NIB_BUFCTRL 4'h0
`define NIB_ID 4'h1
`define NIB_DATA 4'h6
`define NIB_MODESTAT 4'hE
`define NIB_MODECTRL 4'hF
`define TRANSMIT_REQUEST_BIT_BIT 3
`define RX0IF_BIT 0
`define RX1IF_BIT 1
`define TX0IF_BIT 2
`define TX1IF_BIT 3
`define TX2IF_BIT 4
`define RST_MODESTAT 8'h80
`define RST_MODECTRL 8'hE7
`define RST_OTHER 8'h00
`define MASK_ALL 8'hFF
`define BM_PIN_LO 7'h0C
`define BM_PIN_HI 7'h0D
`define BM_INT_LO 7'h2B
`define BM_INT_HI 7'h2D

// ----------------------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------------------
`define BIT_LAST 3'h7
`define PIN_IDLE 3'h2

`endif

// ===== hdl/reg_file_ram.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Byte-wide register array, one write port and one registered read port
// ----------------------------------------------------------------------------
module reg_file_ram #(
  parameter AW = 7,
  parameter DW = 8
) (
  input wire clk,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [DW-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Contents are not reset here; the owner sweeps defaults in after reset.
  always @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

// ===== hdl/spi_command_decoder.v
`timescale 1ns/1ps
`include "spi_cmd_consts.vh"

// ----------------------------------------------------------------------------
// Serial command interpreter: oversamples the serial pins on sys_clk and acts
// on the controller's register array.
// ----------------------------------------------------------------------------
module spi_command_decoder #(
  parameter AW = 7,
  parameter NTX = 3
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire sckPin,
  input wire csPinN,
  input wire siPin,
  output reg soData_q,
  output reg soOe_q,
  input wire [7:0] intFlagSet,
  input wire [NTX-1:0] txDoneClr,
  input wire [4:0] rxBuf0Info,
  input wire [4:0] rxBuf1Info,
  output reg [7:0] intFlags_q,
  output wire [NTX-1:0] txRequest,
  output reg softResetPulse_q,
  output reg initBusy_q
);

  // --------------------------------------------------------------------------
  // State codes
  // --------------------------------------------------------------------------
  localparam [2:0] S_CMD = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_RDATA = 3'h2;
  localparam [2:0] S_WDATA = 3'h3;
  localparam [2:0] S_BMMASK = 3'h4;
  localparam [2:0] S_BMDATA = 3'h5;
  localparam [2:0] S_STAT = 3'h6;
  localparam [2:0] S_IGN = 3'h7;

  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg [2:0] sync3_q;
  reg [2:0] filt_q;
  reg [2:0] filtPrev_q;
  reg [2:0] state_q;
  reg [2:0] bitCnt_q;
  reg [7:0] shiftIn_q;
  reg [7:0] op_q;
  reg [7:0] ptr_q;
  reg [7:0] mask_q;
  reg [7:0] oldVal_q;
  reg [7:0] txShift_q;
  reg [AW-1:0] rdAddr_q;
  reg ld1_q;
  reg ld2_q;
  reg ldOld_q;
  reg statKind_q;
  reg rxClrPend_q;
  reg rxClrIdx_q;
  reg [AW-1:0] initAddr_q;
  reg memWe_q;
  reg [AW-1:0] memWa_q;
  reg [7:0] memWd_q;
  reg [8*NTX-1:0] txCtrl_q;
  wire [7:0] memRd;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Order is {sck, chip select, serial in}. A filtered level only follows
  // once stages two and three agree, which rejects single-sample glitches.
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sync1_q <= `PIN_IDLE;
      sync2_q <= `PIN_IDLE;
      sync3_q <= `PIN_IDLE;
      filt_q <= `PIN_IDLE;
      filtPrev_q <= `PIN_IDLE;
    end
    else
    begin
      sync1_q <= {sckPin, csPinN, siPin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));
      filtPrev_q <= filt_q;
    end
  end

  // Edges of the filtered serial clock and chip select.
  wire sck = filt_q[2];
  wire csN = filt_q[1];
  wire si = filt_q[0];
  wire sckRise = sck & ~filtPrev_q[2];
  wire sckFall = ~sck & filtPrev_q[2];
  wire csRise = csN & ~filtPrev_q[1];
  wire active = ~csN & ~initBusy_q;
  wire byteDone = active & sckRise & (bitCnt_q == `BIT_LAST);
  wire [7:0] byteIn = {shiftIn_q[6:0], si};

  // --------------------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------------------
  wire isRdRx = (byteIn & `OPM_RDRX) == `OPV_RDRX;
  wire isLdTx = ((byteIn & `OPM_LDTX) == `OPV_LDTX) & ~(byteIn[2] & byteIn[1]);
  wire isRts = (byteIn & `OPM_RTS) == `OPV_RTS;
  wire cmdNow = byteDone & (state_q == S_CMD);
  wire rtsNow = cmdNow & isRts;
  wire rstNow = cmdNow & (byteIn == `OP_RESET);
  wire [2:0] rdRxRow = `RXB_ROW0 + {2'h0, byteIn[2]};
  wire [AW-1:0] rdRxAddr = {rdRxRow, (byteIn[1] ? `NIB_DATA : `NIB_ID)};
  wire [2:0] ldTxRow = `TXB_ROW0 + {1'h0, byteIn[2:1]};
  wire [AW-1:0] ldTxAddr = {ldTxRow, (byteIn[0] ? `NIB_DATA : `NIB_ID)};
  wire rxClrNow = csRise & rxClrPend_q;

  // Bit-modifiable locations: buffer control rows, mode control, pin and
  // interrupt registers.
  function bmOk;
    input [AW-1:0] a;
    begin
      bmOk = ((a[3:0] == `NIB_BUFCTRL) && (a[6:4] >= `TXB_ROW0))
        || (a[3:0] == `NIB_MODECTRL)
        || (a >= `BM_PIN_LO && a <= `BM_PIN_HI)
        || (a >= `BM_INT_LO && a <= `BM_INT_HI);
    end
  endfunction

  // Default value of one location, used by the initialisation sweep.
  function [7:0] dflt;
    input [AW-1:0] a;
    begin
      if (a[3:0] == `NIB_MODESTAT)
        dflt = `RST_MODESTAT;
      else if (a[3:0] == `NIB_MODECTRL)
        dflt = `RST_MODECTRL;
      else
        dflt = `RST_OTHER;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Write path
  // --------------------------------------------------------------------------
  // A data byte is committed only on its eighth rising edge, so a frame cut
  // short leaves earlier bytes written and the partial one dropped.
  wire wrNow = byteDone & ((state_q == S_WDATA) | (state_q == S_BMDATA));
  wire [AW-1:0] wrAddr = ptr_q[AW-1:0];
  wire [7:0] effMask = bmOk(wrAddr) ? mask_q : `MASK_ALL;
  wire [7:0] wrVal = (state_q == S_BMDATA) ?
    ((oldVal_q & ~effMask) | (byteIn & effMask)) : byteIn;
  wire wrIntHit = wrNow & (wrAddr == `ADDR_INTFLAG);
  wire [NTX-1:0] wrTxHit;
  wire [NTX-1:0] rdTxHit;
  wire [8*NTX-1:0] txRdVal;

  // --------------------------------------------------------------------------
  // Transmit buffer control registers, one per buffer
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NTX; gi = gi + 1)
    begin : gTx
      localparam integer ROWI = `TXB_ROW0 + gi;
      localparam [2:0] ROW = ROWI[2:0];
      localparam [AW-1:0] TXA = {ROW, `NIB_BUFCTRL};
      reg [7:0] base;
      assign wrTxHit[gi] = wrNow & (wrAddr == TXA);
      assign rdTxHit[gi] = rdAddr_q == TXA;
      assign txRdVal[8*gi+7:8*gi] = rdTxHit[gi] ? txCtrl_q[8*gi+7:8*gi] : 8'h00;
      assign txRequest[gi] = txCtrl_q[8*gi+`TRANSMIT_REQUEST_BIT_BIT];

      // The request set wins over a completion clear in the same cycle.
      always @*
      begin
        base = wrTxHit[gi] ? wrVal : txCtrl_q[8*gi+7:8*gi];
        if (txDoneClr[gi])
          base[`TRANSMIT_REQUEST_BIT_BIT] = 1'b0;
        if (rtsNow && byteIn[gi])
          base[`TRANSMIT_REQUEST_BIT_BIT] = 1'b1;
      end

      always @(posedge sys_clk)
      begin
        if (sys_rst || rstNow)
          txCtrl_q[8*gi+7:8*gi] <= `RST_OTHER;
        else
          txCtrl_q[8*gi+7:8*gi] <= base;
      end
    end
  endgenerate

  wire hotWr = wrIntHit | (|wrTxHit);
  wire rdIntHit = rdAddr_q == `ADDR_INTFLAG;
  wire [7:0] rdByte = rdIntHit ? intFlags_q :
    ((|rdTxHit) ? (txRdVal[7:0] | txRdVal[15:8] | txRdVal[23:16]) : memRd);

  // --------------------------------------------------------------------------
  // Quick status bytes
  // --------------------------------------------------------------------------
  // Layout of the general status byte pairs each transmit request with its
  // completion flag above the two receive flags.
  wire [7:0] rdStatus = {intFlags_q[`TX2IF_BIT], txCtrl_q[16+`TRANSMIT_REQUEST_BIT_BIT],
    intFlags_q[`TX1IF_BIT], txCtrl_q[8+`TRANSMIT_REQUEST_BIT_BIT],
    intFlags_q[`TX0IF_BIT], txCtrl_q[`TRANSMIT_REQUEST_BIT_BIT],
    intFlags_q[`RX1IF_BIT], intFlags_q[`RX0IF_BIT]};
  // Buffer zero has priority when both hold a message.
  wire [4:0] rxInfo = intFlags_q[`RX0IF_BIT] ? rxBuf0Info :
    (intFlags_q[`RX1IF_BIT] ? rxBuf1Info : 5'h00);
  wire [7:0] rxStatus = {intFlags_q[`RX1IF_BIT], intFlags_q[`RX0IF_BIT], 1'b0,
    rxInfo};

  // --------------------------------------------------------------------------
  // Interrupt flag register
  // --------------------------------------------------------------------------
  // Hardware set beats both the software write and the end-of-read clear.
  always @(posedge sys_clk)
  begin
    if (sys_rst || rstNow)
      intFlags_q <= `RST_OTHER;
    else
      intFlags_q <= ((wrIntHit ? wrVal : intFlags_q)
        & ~(rxClrNow ? (8'h01 << rxClrIdx_q) : 8'h00)) | intFlagSet;
  end

  // --------------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------------
  // Reads take two cycles to reach the output shifter, well inside half a
  // serial clock period, so the byte is ready before the next falling edge.
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= S_CMD;
      bitCnt_q <= 3'h0;
      shiftIn_q <= 8'h00;
      op_q <= 8'h00;
      ptr_q <= 8'h00;
      mask_q <= 8'h00;
      oldVal_q <= 8'h00;
      txShift_q <= 8'h00;
      rdAddr_q <= {AW{1'b0}};
      ld1_q <= 1'b0;
      ld2_q <= 1'b0;
      ldOld_q <= 1'b0;
      statKind_q <= 1'b0;
      rxClrPend_q <= 1'b0;
      rxClrIdx_q <= 1'b0;
      soData_q <= 1'b0;
      soOe_q <= 1'b0;
    end
    else
    begin
      ld1_q <= 1'b0;
      ld2_q <= ld1_q;
      if (ld2_q && ldOld_q)
        oldVal_q <= rdByte;
      else if (ld2_q)
      begin
        txShift_q <= rdByte;
        soOe_q <= 1'b1;
      end
      if (csN)
      begin
        // Chip select high ends any operation and re-arms for an opcode.
        state_q <= S_CMD;
        bitCnt_q <= 3'h0;
        soOe_q <= 1'b0;
        soData_q <= 1'b0;
        rxClrPend_q <= 1'b0;
      end
      else
      begin
        if (active && sckRise)
        begin
          shiftIn_q <= byteIn;
          bitCnt_q <= bitCnt_q + 3'h1;
        end
        if (active && sckFall && soOe_q)
        begin
          soData_q <= txShift_q[7];
          txShift_q <= {txShift_q[6:0], 1'b0};
        end
        if (byteDone)
        begin
          case (state_q)
            S_CMD:
            begin
              op_q <= byteIn;
              if (byteIn == `OP_READ || byteIn == `OP_WRITE || byteIn == `OP_BITMOD)
                state_q <= S_ADDR;
              else if (isRdRx)
              begin
                rdAddr_q <= rdRxAddr;
                ptr_q <= {1'b0, rdRxAddr} + 8'h01;
                ld1_q <= 1'b1;
                ldOld_q <= 1'b0;
                rxClrPend_q <= 1'b1;
                rxClrIdx_q <= byteIn[2];
                state_q <= S_RDATA;
              end
              else if (isLdTx)
              begin
                ptr_q <= {1'b0, ldTxAddr};
                state_q <= S_WDATA;
              end
              else if (byteIn == `OP_RDSTAT || byteIn == `OP_RXSTAT)
              begin
                statKind_q <= (byteIn == `OP_RXSTAT);
                txShift_q <= (byteIn == `OP_RXSTAT) ? rxStatus : rdStatus;
                soOe_q <= 1'b1;
                state_q <= S_STAT;
              end
              else
                state_q <= S_IGN;
            end
            S_ADDR:
            begin
              ptr_q <= byteIn;
              if (op_q == `OP_READ)
              begin
                rdAddr_q <= byteIn[AW-1:0];
                ptr_q <= byteIn + 8'h01;
                ld1_q <= 1'b1;
                ldOld_q <= 1'b0;
                state_q <= S_RDATA;
              end
              else if (op_q == `OP_WRITE)
                state_q <= S_WDATA;
              else
                state_q <= S_BMMASK;
            end
            S_RDATA:
            begin
              rdAddr_q <= ptr_q[AW-1:0];
              ptr_q <= ptr_q + 8'h01;
              ld1_q <= 1'b1;
              ldOld_q <= 1'b0;
            end
            S_WDATA:
              ptr_q <= ptr_q + 8'h01;
            S_BMMASK:
            begin
              mask_q <= byteIn;
              rdAddr_q <= ptr_q[AW-1:0];
              ld1_q <= 1'b1;
              ldOld_q <= 1'b1;
              state_q <= S_BMDATA;
            end
            S_BMDATA:
              state_q <= S_IGN;
            S_STAT:
              txShift_q <= statKind_q ? rxStatus : rdStatus;
            default:
              state_q <= S_IGN;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Array write port and default sweep
  // --------------------------------------------------------------------------
  // The sweep takes one cycle per location; commands are refused until it
  // ends, trading a short blind window for a plain array with one write port.
  always @(posedge sys_clk)
  begin
    if (sys_rst || rstNow)
    begin
      initBusy_q <= 1'b1;
      initAddr_q <= {AW{1'b0}};
      memWe_q <= 1'b0;
      memWa_q <= {AW{1'b0}};
      memWd_q <= 8'h00;
    end
    else if (initBusy_q)
    begin
      memWe_q <= 1'b1;
      memWa_q <= initAddr_q;
      memWd_q <= dflt(initAddr_q);
      initAddr_q <= initAddr_q + {{(AW-1){1'b0}}, 1'b1};
      if (&initAddr_q)
        initBusy_q <= 1'b0;
    end
    else
    begin
      memWe_q <= wrNow & ~hotWr;
      memWa_q <= wrAddr;
      memWd_q <= wrVal;
    end
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
      softResetPulse_q <= 1'b0;
    else
      softResetPulse_q <= rstNow;
  end

  reg_file_ram #(
    .AW(AW),
    .DW(8)
  ) uRam (
    .clk(sys_clk),
    .wrEn(memWe_q),
    .wrAddr(memWa_q),
    .wrData(memWd_q),
    .rdAddr(rdAddr_q),
    .rdData(memRd)
  );

endmodule

// ===== tb/spi_cmd_chk.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Port checks of the serial command interpreter
// ----------------------------------------------------------------------------
module spi_cmd_chk #(
  parameter NTX = 3
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire sckPin,
  input wire csPinN,
  input wire siPin,
  input wire soData_q,
  input wire soOe_q,
  input wire [7:0] intFlagSet,
  input wire [NTX-1:0] txDoneClr,
  input wire [4:0] rxBuf0Info,
  input wire [4:0] rxBuf1Info,
  input wire [7:0] intFlags_q,
  input wire [NTX-1:0] txRequest,
  input wire softResetPulse_q,
  input wire initBusy_q
);
  logic [3:0] csHighCnt = 4'h0;
  logic [3:0] sckFallAge = 4'h0;
  logic sckPrev = 1'b0;
  logic [7:0] busyCnt = 8'h00;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Saturating age counters, so a long idle never wraps into a false trigger.
  always @(posedge sys_clk)
  begin
    csHighCnt <= !csPinN ? 4'h0 : (csHighCnt == 4'hF) ? csHighCnt : csHighCnt + 4'h1;
    sckPrev <= sckPin;
    sckFallAge <= (sckPrev && !sckPin) ? 4'h0 :
      (sckFallAge == 4'hF) ? sckFallAge : sckFallAge + 4'h1;
    // The pulse rises in the same cycle as the restarted sweep, so its own cycle counts here.
    busyCnt <= sys_rst ? 8'h00 : softResetPulse_q ? 8'h01 :
      (initBusy_q && busyCnt != 8'hFF) ? busyCnt + 8'h01 : busyCnt;
  end

  cs_idle_quiet_a: assert property (csPinN [*6] |-> !soOe_q)
    else $error("serial output still enabled with chip select high");
  so_idle_low_a: assert property (!soOe_q |-> !soData_q)
    else $error("serial output not idle while undriven");
  so_on_fall_a: assert property ((soOe_q && $past(soOe_q) && $changed(soData_q)) |->
    sckFallAge >= 4'h3 && sckFallAge <= 4'h5) else $error("serial output moved away from a clock fall");
  busy_len_a: assert property ($fell(initBusy_q) |-> busyCnt >= 8'h80)
    else $error("default sweep ended early");
  sweep_start_a: assert property ((softResetPulse_q && intFlagSet == 8'h00) |->
    ##[1:2] (initBusy_q && intFlags_q == 8'h00)) else $error("soft reset did not restart");
  pulse_once_a: assert property (softResetPulse_q |=> !softResetPulse_q)
    else $error("soft reset pulse too long");
  transmit_request_bit_idle_a: assert property ((csHighCnt >= 4'h8 && !(|txDoneClr)) |=>
    $stable(txRequest)) else $error("transmit request moved while deselected");
  flags_idle_a: assert property ((csHighCnt >= 4'h8 && intFlagSet == 8'h00) |=>
    $stable(intFlags_q)) else $error("flags moved while deselected");
  txdone_clr_a: assert property ((csHighCnt >= 4'h8 && txDoneClr[0]) |=> !txRequest[0])
    else $error("transmit request not cleared by done pulse");
  flag_set_a: assert property (intFlagSet[1] |=> intFlags_q[1])
    else $error("flag set pulse lost");

  cover property ($rose(txRequest[NTX-1]));
  cover property ($fell(intFlags_q[0]));
  cover property ($rose(soOe_q));
  cover property (softResetPulse_q);
endmodule

bind spi_command_decoder spi_cmd_chk #(.NTX(NTX)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .sckPin(sckPin), .csPinN(csPinN), .siPin(siPin),
  .soData_q(soData_q), .soOe_q(soOe_q), .intFlagSet(intFlagSet), .txDoneClr(txDoneClr),
  .rxBuf0Info(rxBuf0Info), .rxBuf1Info(rxBuf1Info), .intFlags_q(intFlags_q),
  .txRequest(txRequest), .softResetPulse_q(softResetPulse_q), .initBusy_q(initBusy_q)
);

// ===== tb/spi_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host serial master: 200 ns clock, still between frames
// ----------------------------------------------------------------------------
module spi_host_model (
  input wire logic sys_clk,
  input wire logic soData_q,
  input wire logic soOe_q,
  output logic sckPin,
  output logic csPinN,
  output logic siPin,
  output logic [7:0] rxByte,
  output logic rxValid
);
  logic cpol = 1'b0;

  // Deselected and idle from time zero.
  initial
  begin
    sckPin = 1'b0;
    csPinN = 1'b1;
    siPin = 1'b1;
    rxByte = 8'h00;
    rxValid = 1'b0;
  end

  // Selects the device with the clock parked at the idle level of the mode.
  task automatic frame_start(input logic mode11);
    cpol = mode11;
    sckPin <= mode11;
    repeat (4) @(posedge sys_clk);
    csPinN <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  // Data changes with the fall, reply is taken late in the high phase.
  // An undriven output reads high, so a silent device cannot pass for zeros.
  task automatic xbyte(input logic [7:0] tx, input int nb, input logic keep);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      sckPin <= 1'b0;
      siPin <= tx[i];
      repeat (4) @(posedge sys_clk);
      sckPin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      r[i] = soOe_q ? soData_q : 1'b1;
    end
    if (keep)
    begin
      rxByte <= r;
      rxValid <= 1'b1;
      @(posedge sys_clk);
      rxValid <= 1'b0;
    end
  endtask

  // Released data line shows the inverse, so nothing stale can pass for data.
  task automatic frame_stop;
    sckPin <= cpol;
    repeat (2) @(posedge sys_clk);
    csPinN <= 1'b1;
    siPin <= ~siPin;
    repeat (12) @(posedge sys_clk);
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Self-checking bench for the serial command interpreter
// ----------------------------------------------------------------------------
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst;
  logic sckPin, csPinN, siPin, soData_q, soOe_q, softResetPulse_q, initBusy_q, rxValid;
  logic [7:0] intFlagSet;
  logic [2:0] txDoneClr;
  logic [4:0] rxBuf0Info;
  logic [4:0] rxBuf1Info;
  logic [7:0] intFlags_q, rxByte, v;
  logic [7:0] obsVal = 8'h00;
  logic obsValid = 1'b0;
  logic [2:0] txRequest;
  logic [7:0] d [3];
  logic [7:0] expQ [$];
  int errTotal = 0;
  int cmpCount = 0;
  int cycCount = 0;

  always #12.5 sys_clk = ~sys_clk;

  spi_command_decoder u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sckPin(sckPin),
    .csPinN(csPinN), .siPin(siPin), .soData_q(soData_q), .soOe_q(soOe_q),
    .intFlagSet(intFlagSet), .txDoneClr(txDoneClr), .rxBuf0Info(rxBuf0Info),
    .rxBuf1Info(rxBuf1Info), .intFlags_q(intFlags_q), .txRequest(txRequest),
    .softResetPulse_q(softResetPulse_q), .initBusy_q(initBusy_q));
  spi_host_model u_host (.sys_clk(sys_clk), .soData_q(soData_q), .sckPin(sckPin),
    .soOe_q(soOe_q), .csPinN(csPinN), .siPin(siPin), .rxByte(rxByte), .rxValid(rxValid));

  // Verdict; every way out of the run comes through here.
  task automatic completeRun;
    $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Port values go through the same queue as serial replies.
  task automatic portChk(input logic [7:0] got, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge sys_clk);
    obsVal <= got;
    obsValid <= 1'b1;
    @(posedge sys_clk);
    obsValid <= 1'b0;
  endtask

  // One whole command frame; filler bytes during replies are random.
  task automatic run(input logic [7:0] b[$], input int nrd, input logic m11);
    u_host.frame_start(m11);
    foreach (b[i]) u_host.xbyte(b[i], 8, 1'b0);
    repeat (nrd) u_host.xbyte(8'($urandom), 8, 1'b1);
    u_host.frame_stop();
  endtask

  task automatic pulse(input logic [7:0] f, input logic [2:0] c);
    intFlagSet <= f;
    txDoneClr <= c;
    @(posedge sys_clk);
    intFlagSet <= 8'h00;
    txDoneClr <= 3'h0;
    @(posedge sys_clk);
  endtask

  // Frames are refused during the default sweep, so wait it out, bounded.
  task automatic waitIdle;
    for (int i = 0; i < 400 && initBusy_q !== 1'b0; i++) @(posedge sys_clk);
    if (initBusy_q !== 1'b0)
    begin
      errTotal++;
      $display("[FAIL] %0t default sweep never ended", $time);
    end
    repeat (8) @(posedge sys_clk);
  endtask

  // Write, masked write, then read back the result.
  task automatic bitMod(input logic [7:0] a, o, m, dt, e);
    run('{8'h02, a, o}, 0, 1'b0);
    run('{8'h05, a, m, dt}, 0, 1'b0);
    expQ.push_back(e);
    run('{8'h03, a}, 1, 1'b0);
  endtask

  // Takes the oldest expectation whenever a reply byte or port sample appears.
  always @(posedge sys_clk)
  begin
    if (rxValid || obsValid)
    begin
      cmpCount++;
      if (expQ.size() == 0 || (rxValid ? rxByte : obsVal) !== expQ[0])
      begin
        errTotal++;
        $display("[FAIL] %0t got %h", $time, rxValid ? rxByte : obsVal);
      end
      if (expQ.size() != 0)
        void'(expQ.pop_front());
    end
  end

  // Cuts a hang short; the tests need about 8400 cycles.
  always @(posedge sys_clk)
  begin
    cycCount++;
    if (cycCount == 90000)
    begin
      errTotal++;
      $display("[FAIL] %0t run timed out", $time);
      completeRun();
    end
  end

  // Main sequence.
  initial
  begin
    sys_rst <= 1'b1;
    intFlagSet <= 8'h00;
    txDoneClr <= 3'h0;
    rxBuf0Info <= 5'h00;
    rxBuf1Info <= 5'h00;
    v = 8'($urandom(41345));
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    waitIdle();
    portChk(intFlags_q, 8'h00);
    foreach (d[i]) d[i] = 8'($urandom);
    u_host.frame_start(1'b0);
    u_host.xbyte(8'h02, 8, 1'b0);
    u_host.xbyte(8'h31, 8, 1'b0);
    foreach (d[i]) u_host.xbyte(d[i], 8, 1'b0);
    u_host.xbyte(8'hFF, 5, 1'b0);
    u_host.frame_stop();
    foreach (d[i]) expQ.push_back(d[i]);
    expQ.push_back(8'h00);
    run('{8'h03, 8'h31}, 4, 1'b0);
    expQ.push_back(8'h80);
    expQ.push_back(8'hE7);
    run('{8'h03, 8'h0E}, 2, 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($urandom);
      run('{8'h40 | 8'(k), v}, 0, 1'b0);
      expQ.push_back(v);
      run('{8'h03, {1'b0, 3'(3 + k / 2), (k % 2) ? 4'h6 : 4'h1}}, 1, 1'b0);
    end
    for (int n = 0; n < 8; n++)
    begin
      pulse(8'h00, 3'h7);
      run('{8'h80 | 8'(n)}, 0, 1'b0);
      portChk({5'h00, txRequest}, 8'(n));
    end
    bitMod(8'h30, 8'h08, 8'h08, 8'h00, 8'h00);
    portChk({5'h00, txRequest}, 8'h06);
    expQ.push_back(8'h08);
    run('{8'h03, 8'h40}, 1, 1'b0);
    bitMod(8'h2B, 8'h5A, 8'h0F, 8'hA5, 8'h55);
    bitMod(8'h2A, 8'h3C, 8'h0F, 8'hC3, 8'hC3);
    rxBuf0Info <= 5'($urandom);
    rxBuf1Info <= 5'($urandom);
    v = 8'($urandom);
    run('{8'h02, 8'h66, v}, 0, 1'b0);
    d[0] = {3'($urandom), 5'h1F};
    pulse(d[0], 3'h0);
    repeat (2) expQ.push_back(8'hFB);
    run('{8'hA0}, 2, 1'b0);
    repeat (2) expQ.push_back({3'b110, rxBuf0Info});
    run('{8'hB0}, 2, 1'b0);
    expQ.push_back(v);
    run('{8'h92}, 1, 1'b0);
    portChk(intFlags_q, d[0] & 8'hFE);
    expQ.push_back({3'b100, rxBuf1Info});
    run('{8'hB0}, 1, 1'b0);
    expQ.push_back(8'h00);
    run('{8'h94}, 1, 1'b0);
    portChk(intFlags_q, d[0] & 8'hFC);
    expQ.push_back(8'h00);
    run('{8'hB0}, 1, 1'b0);
    expQ.push_back(8'hFF);
    run('{8'hFF, 8'h02, 8'h31}, 1, 1'b0);
    run('{8'hC0}, 0, 1'b0);
    waitIdle();
    portChk(intFlags_q, 8'h00);
    portChk({5'h00, txRequest}, 8'h00);
    expQ.push_back(8'h00);
    run('{8'h03, 8'h66}, 1, 1'b0);
    if (expQ.size() != 0)
    begin
      errTotal++;
      $display("[FAIL] %0t replies missing", $time);
    end
    completeRun();
  end
endmodule
